// ===== fsh_host.sv
`timescale 1ns/100ps
`include "fsh_cfg.svh"
module fsh_host
  import fsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_out,
  input wire logic [15:0] flash_dq_in,
  output logic flash_dq_oe_n,
  input wire logic ready_busy_out
);
  localparam logic [8:0] RLOW_LAST = 9'(`FSH_RST_LOW_CYC - 1);
  localparam logic [8:0] ISM_CYC = 9'(`FSH_ISM_RST_CYC);
  localparam logic [8:0] REC_LAST = 9'(`FSH_RST_REC_CYC - 1);

  fsh_cyc_if cyc();
  fsh_reg_if rif();

  fsh_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif.regs)
  );

  fsh_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .cyc(cyc.eng),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_in(flash_dq_in),
    .flash_dq_oe_n(flash_dq_oe_n)
  );

  // {write, address, data} of one step of a command sequence
  function automatic logic [35:0] fsh_step(input fsh_op_t op,
    input logic [1:0] step, input logic [18:0] a, input logic [15:0] d);
    logic [15:0] cmd;
    cmd = (op == FSH_OP_RESET) ? `FSH_CMD_RESET :
      (op == FSH_OP_ID) ? `FSH_CMD_ID : `FSH_CMD_PROG;
    unique case (step)
      2'h0: fsh_step = (op == FSH_OP_READ) ? {1'b0, a, 16'h0000} :
        {1'b1, `FSH_UNLK1_ADDR, `FSH_CMD_UNLK1};
      2'h1: fsh_step = {1'b1, `FSH_UNLK2_ADDR, `FSH_CMD_UNLK2};
      2'h2: fsh_step = {1'b1, `FSH_UNLK1_ADDR, cmd};
      2'h3: fsh_step = (op == FSH_OP_ID) ? {1'b0, a, 16'h0000} :
        {1'b1, a, d};
    endcase
  endfunction

  function automatic logic [1:0] fsh_last(input fsh_op_t op);
    unique case (op)
      FSH_OP_READ: fsh_last = 2'h0;
      FSH_OP_RESET: fsh_last = 2'h2;
      default: fsh_last = 2'h3;
    endcase
  endfunction

  fsh_state_t state_reg, state_next;
  fsh_op_t op_reg, op_next;
  logic [1:0] step_reg, step_next;
  logic [18:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [8:0] cnt_reg, cnt_next;
  logic req_reg, req_next;
  logic rst_n_reg, rst_n_next;
  logic fail_reg, fail_next;
  logic to_seen_reg, to_seen_next;

  wire [35:0] step_word = fsh_step(op_reg, step_reg, addr_reg, wdata_reg);
  wire step_last = step_reg == fsh_last(op_reg);
  wire in_poll = state_reg == FSH_ST_POLL;
  wire poll_ok = cyc.rdata[`FSH_POLL_BIT] == wdata_reg[`FSH_POLL_BIT];
  wire to_set = cyc.rdata[`FSH_TO_BIT];
  wire cnt_max = cnt_reg >= ISM_CYC;

  // command writes carry a zero upper byte, the program word write carries wdata_reg; unlock addresses sit in low bits
  assign cyc.req = req_reg;
  assign cyc.wr = !in_poll && step_word[35];
  assign cyc.addr = in_poll ? addr_reg : step_word[34:16];
  assign cyc.wdata = step_word[15:0];
  assign flash_reset_n = rst_n_reg;
  assign rif.busy = state_reg != FSH_ST_IDLE;
  assign rif.fail = fail_reg;
  assign rif.rdy = ready_busy_out;
  assign rif.rdata = rdata_reg;

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cnt_next = cnt_reg;
    req_next = req_reg;
    rst_n_next = rst_n_reg;
    fail_next = fail_reg;
    to_seen_next = to_seen_reg;
    unique case (state_reg)
      FSH_ST_IDLE:
        if (rif.go)
        begin
          op_next = rif.op;
          addr_next = rif.addr;
          wdata_next = rif.wdata;
          fail_next = 1'b0;
          step_next = 2'h0;
          cnt_next = 9'h000;
          to_seen_next = 1'b0;
          if (rif.op == FSH_OP_HWRST)
          begin
            rst_n_next = 1'b0;
            state_next = FSH_ST_RLOW;
          end
          else
          begin
            req_next = 1'b1;
            state_next = FSH_ST_CMD;
          end
        end
      FSH_ST_RLOW:
      begin
        cnt_next = cnt_reg + 9'h001;
        if (cnt_reg == RLOW_LAST)
        begin
          rst_n_next = 1'b1;
          state_next = FSH_ST_RWAIT;
        end
      end
      FSH_ST_RWAIT:
      begin
        // counter saturates so a stuck busy pin cannot wrap it
        cnt_next = cnt_max ? cnt_reg : cnt_reg + 9'h001;
        if (cnt_max && ready_busy_out)
        begin
          cnt_next = 9'h000;
          state_next = FSH_ST_RREC;
        end
      end
      FSH_ST_RREC:
      begin
        cnt_next = cnt_reg + 9'h001;
        if (cnt_reg == REC_LAST)
          state_next = FSH_ST_IDLE;
      end
      FSH_ST_CMD:
        if (cyc.done)
        begin
          if (!step_word[35])
            rdata_next = cyc.rdata;
          if (!step_last)
            step_next = step_reg + 2'h1;
          else if (op_reg == FSH_OP_PROG)
            state_next = FSH_ST_POLL;
          else
          begin
            req_next = 1'b0;
            state_next = FSH_ST_IDLE;
          end
        end
      FSH_ST_POLL:
        if (cyc.done)
        begin
          rdata_next = cyc.rdata;
          if (poll_ok)
          begin
            req_next = 1'b0;
            state_next = FSH_ST_IDLE;
          end
          else if (to_seen_reg)
          begin
            // poll still wrong after the flag: flash is stuck, reset it
            fail_next = 1'b1;
            op_next = FSH_OP_RESET;
            step_next = 2'h0;
            state_next = FSH_ST_CMD;
          end
          else if (to_set)
            to_seen_next = 1'b1;
        end
      default:
      begin
        req_next = 1'b0;
        state_next = FSH_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_reg <= FSH_ST_IDLE;
      op_reg <= FSH_OP_READ;
      step_reg <= 2'h0;
      cnt_reg <= 9'h000;
      req_reg <= 1'b0;
      rst_n_reg <= 1'b1;
      fail_reg <= 1'b0;
      to_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      req_reg <= req_next;
      rst_n_reg <= rst_n_next;
      fail_reg <= fail_next;
      to_seen_reg <= to_seen_next;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      addr_reg <= 19'h00000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
    end

  sequence rst_pulse_s;
    $fell(flash_reset_n) ##10 $rose(flash_reset_n);
  endsequence
  sequence rst_recover_s;
    !req_reg [*2];
  endsequence

  rst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == FSH_ST_IDLE && rif.go && rif.op == FSH_OP_HWRST)
    |=> rst_pulse_s)
    else $error("reset pulse not ten cycles");
  rst_recov_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flash_reset_n) |-> rst_recover_s)
    else $error("bus cycle too soon after reset release");
  busy_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == FSH_ST_RWAIT && !ready_busy_out)
    |=> state_reg == FSH_ST_RWAIT)
    else $error("left reset wait while flash busy");
  unlock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == FSH_ST_CMD && step_reg == 2'h0 && op_reg != FSH_OP_READ)
    |-> cyc.wr && cyc.addr == 19'h00555 && cyc.wdata == 16'h00AA)
    else $error("first unlock write wrong");
  prog_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == FSH_ST_CMD && step_reg == 2'h3 && op_reg == FSH_OP_PROG)
    |-> cyc.wr && cyc.addr == addr_reg && cyc.wdata == wdata_reg)
    else $error("program write not at target");
  poll_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_poll && cyc.done && poll_ok)
    |=> state_reg == FSH_ST_IDLE && !req_reg && !fail_reg)
    else $error("poll match did not end program");
  fail_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_poll && cyc.done && !poll_ok && to_seen_reg)
    |=> state_reg == FSH_ST_CMD && op_reg == FSH_OP_RESET && fail_reg
    ##[1:5] cyc.done)
    else $error("timeout did not start reset command");
endmodule

// ===== fsh_cfg.svh
`ifndef FSH_CFG_SVH
`define FSH_CFG_SVH
`define FSH_CLK_NS 50
`define FSH_RST_LOW_NS 500
`define FSH_RST_LOW_CYC ((`FSH_RST_LOW_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_ISM_RST_US 20
`define FSH_ISM_RST_CYC ((`FSH_ISM_RST_US * 1000 + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_RST_REC_NS 50
`define FSH_RST_REC_CYC ((`FSH_RST_REC_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_ACC_NS 120
`define FSH_ACC_CYC ((`FSH_ACC_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_WP_NS 100
`define FSH_WP_CYC ((`FSH_WP_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_OFF_CTRL 8'h00
`define FSH_OFF_ADDR 8'h04
`define FSH_OFF_WDATA 8'h08
`define FSH_OFF_STATUS 8'h0C
`define FSH_OFF_RDATA 8'h10
`define FSH_ST_BUSY 0
`define FSH_ST_FAIL 1
`define FSH_ST_RDY 2
`define FSH_UNLK1_ADDR 19'h00555
`define FSH_UNLK2_ADDR 19'h002AA
`define FSH_CMD_UNLK1 16'h00AA
`define FSH_CMD_UNLK2 16'h0055
`define FSH_CMD_RESET 16'h00F0
`define FSH_CMD_ID 16'h0090
`define FSH_CMD_PROG 16'h00A0
`define FSH_POLL_BIT 7
`define FSH_TOGGLE_BIT 6
`define FSH_TO_BIT 5
`endif

// ===== fsh_pkg.sv
package fsh_pkg;
  typedef enum logic [2:0] {
    FSH_OP_READ = 3'b000,
    FSH_OP_RESET = 3'b001,
    FSH_OP_ID = 3'b010,
    FSH_OP_PROG = 3'b011,
    FSH_OP_HWRST = 3'b100
  } fsh_op_t;
  typedef enum logic [2:0] {
    FSH_ST_IDLE = 3'b000,
    FSH_ST_RLOW = 3'b001,
    FSH_ST_RWAIT = 3'b010,
    FSH_ST_RREC = 3'b011,
    FSH_ST_CMD = 3'b100,
    FSH_ST_POLL = 3'b101
  } fsh_state_t;
  typedef enum logic [1:0] {
    FSH_C_IDLE = 2'b00,
    FSH_C_SETUP = 2'b01,
    FSH_C_STROBE = 2'b10,
    FSH_C_HOLD = 2'b11
  } fsh_cst_t;
endpackage

// ===== fsh_if.sv
`timescale 1ns/100ps
interface fsh_cyc_if;
  logic req;
  logic wr;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

interface fsh_reg_if;
  logic go;
  fsh_pkg::fsh_op_t op;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic busy;
  logic fail;
  logic rdy;
  logic [15:0] rdata;
  modport regs (output go, op, addr, wdata, input busy, fail, rdy, rdata);
  modport core (input go, op, addr, wdata, output busy, fail, rdy, rdata);
endinterface

// ===== fsh_cycle.sv
`timescale 1ns/100ps
`include "fsh_cfg.svh"
module fsh_cycle
  import fsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  fsh_cyc_if.eng cyc,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_out,
  input wire logic [15:0] flash_dq_in,
  output logic flash_dq_oe_n
);
  localparam logic [1:0] WP_LAST = 2'(`FSH_WP_CYC - 1);
  localparam logic [1:0] ACC_LAST = 2'(`FSH_ACC_CYC - 1);
  fsh_cst_t c_state_reg;
  logic [1:0] ccnt_reg;
  logic wr_reg;
  logic [15:0] rdata_reg;
  wire accept = (c_state_reg == FSH_C_IDLE) && cyc.req;
  wire strobe_end = (c_state_reg == FSH_C_STROBE) &&
    (ccnt_reg == (wr_reg ? WP_LAST : ACC_LAST));
  assign cyc.done = c_state_reg == FSH_C_HOLD;
  assign cyc.rdata = rdata_reg;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      c_state_reg <= FSH_C_IDLE;
      ccnt_reg <= 2'h0;
    end
    else
    begin
      unique case (c_state_reg)
        FSH_C_IDLE: if (accept) c_state_reg <= FSH_C_SETUP;
        FSH_C_SETUP: c_state_reg <= FSH_C_STROBE;
        FSH_C_STROBE: if (strobe_end) c_state_reg <= FSH_C_HOLD;
        FSH_C_HOLD: c_state_reg <= FSH_C_IDLE;
      endcase
      ccnt_reg <= (c_state_reg == FSH_C_STROBE) ? ccnt_reg + 2'h1 : 2'h0;
    end

  // address stays put from chip enable low to release, so the later
  // falling strobe and the earlier rising strobe both see stable lines
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wr_reg <= 1'b0;
      flash_addr <= 19'h00000;
      flash_dq_out <= 16'h0000;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      if (accept)
      begin
        wr_reg <= cyc.wr;
        flash_addr <= cyc.addr;
        flash_dq_out <= cyc.wdata;
      end
      if (strobe_end && !wr_reg)
        rdata_reg <= flash_dq_in;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_oe_n <= 1'b1;
    end
    else
    begin
      flash_ce_n <= !(accept || c_state_reg == FSH_C_SETUP ||
        c_state_reg == FSH_C_STROBE);
      flash_dq_oe_n <= !((accept && cyc.wr) ||
        (wr_reg && c_state_reg != FSH_C_IDLE && !cyc.done));
      flash_we_n <= !(wr_reg && (c_state_reg == FSH_C_SETUP ||
        (c_state_reg == FSH_C_STROBE && !strobe_end)));
      flash_oe_n <= !(!wr_reg && (c_state_reg == FSH_C_SETUP ||
        (c_state_reg == FSH_C_STROBE && !strobe_end)));
    end

  strobe_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(!flash_we_n && !flash_oe_n))
    else $error("write and output strobes low together");
  addr_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!flash_ce_n && $past(!flash_ce_n)) |-> $stable(flash_addr))
    else $error("address moved during a bus cycle");
  dq_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !flash_dq_oe_n |-> flash_oe_n)
    else $error("data driven while output enable low");
  cycle_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |-> ##[3:5] cyc.done)
    else $error("bus cycle did not finish in time");
endmodule

// ===== fsh_apb.sv
`timescale 1ns/100ps
`include "fsh_cfg.svh"
module fsh_apb
  import fsh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fsh_reg_if.regs rif
);
  logic go_reg;
  fsh_op_t op_reg;
  logic [18:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [31:0] prdata_reg;
  wire hit_ctrl = paddr == `FSH_OFF_CTRL;
  wire hit_addr = paddr == `FSH_OFF_ADDR;
  wire hit_wdata = paddr == `FSH_OFF_WDATA;
  wire hit_status = paddr == `FSH_OFF_STATUS;
  wire hit_rdata = paddr == `FSH_OFF_RDATA;
  wire hit = hit_ctrl | hit_addr | hit_wdata | hit_status | hit_rdata;
  wire wr_acc = psel && penable && pwrite && hit;
  wire [31:0] status_word = {29'h0000000, rif.rdy, rif.fail, rif.busy};
  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0000000, op_reg} :
    hit_addr ? {13'h000, addr_reg} :
    hit_wdata ? {16'h0000, wdata_reg} :
    hit_status ? status_word :
    hit_rdata ? {16'h0000, rif.rdata} : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;
  assign rif.go = go_reg;
  assign rif.op = op_reg;
  assign rif.addr = addr_reg;
  assign rif.wdata = wdata_reg;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      go_reg <= 1'b0;
      op_reg <= FSH_OP_READ;
      addr_reg <= 19'h00000;
      wdata_reg <= 16'h0000;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      // an order while busy is dropped: the sequencer cannot queue one
      go_reg <= wr_acc && hit_ctrl && !rif.busy;
      if (wr_acc && hit_ctrl && !rif.busy)
        op_reg <= fsh_op_t'(pwdata[2:0]);
      if (wr_acc && hit_addr)
        addr_reg <= pwdata[18:0];
      if (wr_acc && hit_wdata)
        wdata_reg <= pwdata[15:0];
      if (psel && !penable)
        prdata_reg <= rd_mux;
    end

  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unaligned access not refused");
endmodule

// ===== fsh_flash_model.sv
`timescale 1ns/100ps
module fsh_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00C3, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h1A2B, // arbitrary value
  parameter logic [6:0] PROT_SECTOR = 7'h03,
  parameter int PROG_NS = 3000,
  parameter int RST_NS = 20000
) (
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_out
);
  logic [15:0] mem [logic [18:0]];
  logic [18:0] wa;
  logic [18:0] pa;
  logic [15:0] pd;
  logic [15:0] rd = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic id_mode = 1'b0;
  logic armed = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic to_flag = 1'b0;
  logic wsel = 1'b0;
  int step = 0;
  int n_wr = 0;
  int bad = 0;
  realtime t_fall = -1.0e6;
  realtime t_rise = -1.0e3;
  event prog_go;

  function automatic logic [15:0] arr(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  initial ready_busy_out = 1'b1;
  // released bus shows the inverse so stale data never passes
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd : ~last;

  always @(negedge flash_oe_n or negedge flash_ce_n or flash_addr)
    if (!flash_ce_n && !flash_oe_n)
    begin
      if ($realtime - t_rise < 50) bad++;
      if (busy) rd = {8'h00, ~pd[7], tog, to_flag, 5'h00};
      else if (id_mode && flash_addr[7:0] == 8'h00) rd = MAKER_ID;
      else if (id_mode && flash_addr[7:0] == 8'h01) rd = DEVICE_ID;
      else if (id_mode && flash_addr[7:0] == 8'h02)
        rd = {15'h0000, flash_addr[18:12] == PROT_SECTOR};
      else rd = arr(flash_addr);
    end

  always @(posedge flash_oe_n)
  begin
    last = rd;
    if (busy) tog = ~tog;
  end

  always @(negedge flash_we_n or negedge flash_ce_n)
    if (!flash_we_n && !flash_ce_n && flash_reset_n)
    begin
      wa = flash_addr;
      wsel = 1'b1;
    end

  always @(posedge flash_we_n or posedge flash_ce_n)
    if (wsel)
    begin
      wsel = 1'b0;
      n_wr++;
      if (busy)
      begin
        if (to_flag && flash_dq_out[7:0] == 8'hF0)
        begin
          busy = 1'b0;
          to_flag = 1'b0;
          ready_busy_out = 1'b1;
        end
      end
      else if (armed)
      begin
        armed = 1'b0;
        pa = wa;
        pd = flash_dq_out;
        to_flag = |(pd & ~arr(pa));
        mem[pa] = pd & arr(pa);
        busy = 1'b1;
        ready_busy_out = 1'b0;
        -> prog_go;
      end
      else if (flash_dq_out[7:0] == 8'hF0)
      begin
        id_mode = 1'b0;
        step = 0;
      end
      else if (step == 0 && wa[10:0] == 11'h555 && flash_dq_out[7:0] == 8'hAA)
        step = 1;
      else if (step == 1 && wa[10:0] == 11'h2AA && flash_dq_out[7:0] == 8'h55)
        step = 2;
      else if (step == 2 && wa[10:0] == 11'h555)
      begin
        step = 0;
        if (flash_dq_out[7:0] == 8'h90) id_mode = 1'b1;
        if (flash_dq_out[7:0] == 8'hA0) armed = 1'b1;
      end
      else step = 0;
    end

  always @(prog_go)
  begin
    #(PROG_NS);
    if (busy && !to_flag)
    begin
      busy = 1'b0;
      ready_busy_out = 1'b1;
    end
  end

  always @(negedge flash_reset_n)
  begin
    t_fall = $realtime;
    if (busy) mem[pa] = pd ^ 16'h5555;
    {id_mode, armed, busy, to_flag, wsel} = 5'h00;
    step = 0;
    ready_busy_out = 1'b0;
    #(RST_NS);
    ready_busy_out = 1'b1;
  end

  always @(posedge flash_reset_n)
  begin
    t_rise = $realtime;
    if (t_rise - t_fall < 500) bad++;
  end
endmodule

// ===== fsh_host_test.sv
`timescale 1ns/100ps
`include "fsh_cfg.svh"
module fsh_host_test;
  import fsh_pkg::*;
  localparam logic [15:0] MAKER = 16'h00C3; // arbitrary value
  localparam logic [15:0] DEVICE = 16'h1A2B; // arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_dq_oe_n;
  logic [18:0] flash_addr;
  logic [15:0] flash_dq_out;
  logic [15:0] flash_dq_in;
  logic ready_busy_out;
  logic slv;
  logic rb_low;
  int errors = 0;
  int check_count = 0;

  always #25 pclk = ~pclk;

  fsh_host fsh_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_in(flash_dq_in), .flash_dq_oe_n(flash_dq_oe_n),
    .ready_busy_out(ready_busy_out));

  fsh_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) fsh_flash_model_i (
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out));

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input fsh_op_t c, input logic [18:0] a,
    input logic [15:0] d, output logic [31:0] st);
    int n;
    apb(1'b1, `FSH_OFF_ADDR, {13'h0, a}, st);
    apb(1'b1, `FSH_OFF_WDATA, {16'h0, d}, st);
    apb(1'b1, `FSH_OFF_CTRL, {29'h0, c}, st);
    n = 0;
    rb_low = 1'b0;
    do
    begin
      apb(1'b0, `FSH_OFF_STATUS, 32'h0, st);
      if (st[`FSH_ST_RDY] === 1'b0) rb_low = 1'b1;
      n++;
    end while (st[`FSH_ST_BUSY] !== 1'b0 && n < 5000);
    chk("op done", 32'(st[`FSH_ST_BUSY]), 32'h0);
  endtask

  task automatic rdw(input fsh_op_t c, input logic [18:0] a,
    output logic [31:0] q);
    op(c, a, 16'h0, q);
    apb(1'b0, `FSH_OFF_RDATA, 32'h0, q);
  endtask

  task automatic t_power;
    logic [31:0] q;
    chk("flash writes", 32'(fsh_flash_model_i.n_wr), 32'h0);
    chk("dq released", 32'(flash_dq_oe_n), 32'h1);
    apb(1'b0, `FSH_OFF_STATUS, 32'h0, q);
    chk("idle status", q, 32'h4);
    apb(1'b0, 8'h14, 32'h0, q);
    chk("unmapped err", 32'(slv), 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("test power done");
  endtask

  task automatic t_ident;
    logic [31:0] q;
    rdw(FSH_OP_ID, 19'h00000, q);
    chk("maker code", q, {16'h0, MAKER});
    rdw(FSH_OP_ID, 19'h00001, q);
    chk("device code", q, {16'h0, DEVICE});
    rdw(FSH_OP_ID, {7'h03, 12'h002}, q);
    chk("protected", q, 32'h1);
    rdw(FSH_OP_ID, {7'h05, 12'h002}, q);
    chk("unprotected", q, 32'h0);
    rdw(FSH_OP_READ, 19'h00001, q);
    chk("mode kept", q, {16'h0, DEVICE});
    op(FSH_OP_RESET, 19'h0, 16'h0, q);
    rdw(FSH_OP_READ, 19'h00001, q);
    chk("array after exit", q, 32'hFFFF);
    $display("test ident done");
  endtask

  task automatic t_program;
    logic [31:0] q;
    op(FSH_OP_PROG, 19'h41000, 16'hA5A5, q);
    chk("prog status", q, 32'h4);
    chk("busy pin seen", 32'(rb_low), 32'h1);
    op(FSH_OP_PROG, 19'h00010, 16'h1234, q);
    op(FSH_OP_PROG, 19'h00008, 16'h5A5A, q);
    rdw(FSH_OP_READ, 19'h41000, q);
    chk("prog high", q, 32'hA5A5);
    rdw(FSH_OP_READ, 19'h00010, q);
    chk("prog low", q, 32'h1234);
    $display("test program done");
  endtask

  task automatic t_fail;
    logic [31:0] q;
    op(FSH_OP_PROG, 19'h00010, 16'hFFFF, q);
    chk("fail status", q, 32'h6);
    rdw(FSH_OP_READ, 19'h00010, q);
    chk("bits stay clear", q, 32'h1234);
    $display("test fail done");
  endtask

  task automatic t_hwreset;
    logic [31:0] q;
    realtime t0;
    rdw(FSH_OP_ID, 19'h00000, q);
    t0 = $realtime;
    op(FSH_OP_HWRST, 19'h0, 16'h0, q);
    chk("reset status", q, 32'h4);
    chk("pin low seen", 32'(rb_low), 32'h1);
    chk("reset span", 32'($realtime - t0 >= 20000), 32'h1);
    chk("reset timing", 32'(fsh_flash_model_i.bad), 32'h0);
    rdw(FSH_OP_READ, 19'h00008, q);
    chk("array after reset", q, 32'h5A5A);
    $display("test hwreset done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // the whole sequence needs well under 200 us
  initial
  begin
    #1000000;
    errors++;
    end_sim;
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_power;
    t_ident;
    t_program;
    t_fail;
    t_hwreset;
    end_sim;
  end
endmodule
